// [design/emi_pkg.sv]
// Constants for the extended memory indirect access window.
// Assumes byte-wide register offsets on the device's own register port.
package emi_pkg;

  // Register offsets, shared by both byte-order layouts
  localparam logic [7:0] EMI_OFS_30 = 8'h30;
  localparam logic [7:0] EMI_OFS_31 = 8'h31;
  localparam logic [7:0] EMI_OFS_32 = 8'h32;
  localparam logic [7:0] EMI_OFS_33 = 8'h33;
  localparam logic [7:0] EMI_OFS_CTL = 8'h34;
  localparam logic [7:0] EMI_OFS_36 = 8'h36;
  localparam logic [7:0] EMI_OFS_37 = 8'h37;

  // Field positions in the access control register
  localparam int EMI_CTL_ADDR_LSB = 0;
  localparam int EMI_CTL_ADDR_MSB = 4;
  localparam int EMI_CTL_WE_LSB   = 5;
  localparam int EMI_CTL_WE_MSB   = 6;
  localparam int EMI_CTL_START    = 7;

  // Field positions in the partial address registers
  localparam int EMI_A86_LSB = 5;
  localparam int EMI_A25_BIT = 0;

  // Reset values
  localparam logic [7:0]  EMI_BYTE_RST = 8'h00;
  localparam logic [25:1] EMI_ADDR_RST = 25'h0000000;
  localparam logic [1:0]  EMI_WE_RST   = 2'h0;

  // Documented extended address width in bits
  localparam int EMI_ADDR_W = 26;

  typedef enum logic [1:0] {
    EMI_IDLE = 2'b00,
    EMI_BUSY = 2'b01
  } emi_state_type;

  // Logical register selected by an offset and the byte order
  typedef enum logic [2:0] {
    EMI_SEL_NONE = 3'b000,
    EMI_SEL_A86  = 3'b001,
    EMI_SEL_A169 = 3'b010,
    EMI_SEL_A241 = 3'b011,
    EMI_SEL_A25  = 3'b100,
    EMI_SEL_CTL  = 3'b101,
    EMI_SEL_DL   = 3'b110,
    EMI_SEL_DH   = 3'b111
  } emi_sel_type;

endpackage

// [design/emi_data_byte.sv]
// One data byte of the access window: software write, hardware load.
// Assumes both write strobes are on the same clock; hardware load wins.
`timescale 1ns/1ps
module emi_data_byte
  import emi_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic       sw_we,
  input  wire logic [7:0] sw_data,
  input  wire logic       hw_we,
  input  wire logic [7:0] hw_data,
  output logic      [7:0] q
);

  logic [7:0] byte_ff;

  // Read data from the memory overrides a software write in the same cycle
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      byte_ff <= EMI_BYTE_RST;
    end else if (hw_we) begin
      byte_ff <= hw_data;
    end else if (sw_we) begin
      byte_ff <= sw_data;
    end
  end

  assign q = byte_ff;

endmodule

// [design/emi_window.sv]
// Indirect access window onto the word-addressed extended memory.
// Assumes a byte register port and a memory port on the same clock.
//
// How it works
// (R1) Word addressing; address bit zero always zero
// (R2) Address bits 5:1 in control bits 4:0
// (R3) LE 30h: address 8:6 at 7:5
// (R4) Address 16:9 at 31h LE, 32h BE
// (R5) Address 24:17 at 32h LE, 31h BE
// (R6) Address 25 at 33h LE, 30h BE
// (R7) Both enables clear: perform a read
// (R8) Upper enable writes the high byte
// (R9) Lower enable writes the low byte
// (R10) Software sets start bit to launch access
// (R11) Start bit self-clears when access finishes
// (R12) Software loads low byte before a write
// (R13) Read loads the low byte register
// (R14) Software loads high byte before a write
// (R15) Read loads the high byte register
// (R16) Byte-order bit selects layout of 30h-37h
// (R17) Big-endian swaps data high and low offsets
// (R18) Software polls start bit before touching window
`timescale 1ns/1ps
module emi_window
  import emi_pkg::*;
#(
  parameter int ADDR_W = EMI_ADDR_W
)
(
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        big_end,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  output logic             mem_req,
  output logic      [25:0] mem_addr,
  output logic      [1:0]  mem_we,
  output logic      [15:0] mem_wdata,
  input  wire logic        mem_ack,
  input  wire logic [15:0] mem_rdata
);

  // The field layout is fixed at this width
  if (ADDR_W != EMI_ADDR_W) begin : g_width_check
    $error("emi_window: ADDR_W must be 26");
  end

  emi_state_type state_ff;
  emi_state_type nxt_state;
  logic [25:1]   addr_ff;
  logic [1:0]    we_ff;
  logic [7:0]    rdata_ff;
  logic [7:0]    nxt_rdata;
  logic [7:0]    data_lo;
  logic [7:0]    data_hi;
  emi_sel_type   sel;
  logic          busy;
  logic          sw_wr;
  logic          launch;
  logic          done;
  logic          rd_done;

  // Offset to logical register, per byte order
  function automatic emi_sel_type map_offset(
    input logic [7:0] ofs,
    input logic       be
  );
    emi_sel_type s;
    s = EMI_SEL_NONE;
    case (ofs)
      EMI_OFS_30: begin
        s = be ? EMI_SEL_A25 : EMI_SEL_A86; // R16
      end
      EMI_OFS_31: begin
        s = be ? EMI_SEL_A241 : EMI_SEL_A169;
      end
      EMI_OFS_32: begin
        s = be ? EMI_SEL_A169 : EMI_SEL_A241;
      end
      EMI_OFS_33: begin
        s = be ? EMI_SEL_A86 : EMI_SEL_A25;
      end
      EMI_OFS_CTL: begin
        s = EMI_SEL_CTL;
      end
      EMI_OFS_36: begin
        s = be ? EMI_SEL_DH : EMI_SEL_DL; // R17
      end
      EMI_OFS_37: begin
        s = be ? EMI_SEL_DL : EMI_SEL_DH; // R17
      end
      default: begin
        s = EMI_SEL_NONE;
      end
    endcase
    return s;
  endfunction

  assign sel   = map_offset(reg_addr, big_end);
  assign busy  = (state_ff == EMI_BUSY);
  // Window is frozen while an access runs, so a careless write cannot
  // change the address or data under the memory's feet
  assign sw_wr = reg_wr && !busy;
  assign launch = sw_wr && (sel == EMI_SEL_CTL) &&
                  reg_wdata[EMI_CTL_START];
  assign done    = busy && mem_ack;
  assign rd_done = done && (we_ff == 2'h0);

  // Access sequencing
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      EMI_IDLE: begin
        if (launch) begin
          nxt_state = EMI_BUSY;
        end
      end
      EMI_BUSY: begin
        if (mem_ack) begin
          nxt_state = EMI_IDLE; // R11
        end
      end
      default: begin
        nxt_state = EMI_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_ff <= EMI_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Address fields; bit zero is never stored
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      addr_ff <= EMI_ADDR_RST;
    end else if (sw_wr) begin
      case (sel)
        EMI_SEL_CTL: begin
          addr_ff[5:1] <= reg_wdata[EMI_CTL_ADDR_MSB:EMI_CTL_ADDR_LSB]; // R2
        end
        EMI_SEL_A86: begin
          addr_ff[8:6] <= reg_wdata[7:EMI_A86_LSB]; // R3
        end
        EMI_SEL_A169: begin
          addr_ff[16:9] <= reg_wdata; // R4
        end
        EMI_SEL_A241: begin
          addr_ff[24:17] <= reg_wdata; // R5
        end
        EMI_SEL_A25: begin
          addr_ff[25] <= reg_wdata[EMI_A25_BIT]; // R6
        end
        default: begin
          addr_ff <= addr_ff;
        end
      endcase
    end
  end

  // Byte-lane write enables
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      we_ff <= EMI_WE_RST;
    end else if (sw_wr && (sel == EMI_SEL_CTL)) begin
      we_ff <= reg_wdata[EMI_CTL_WE_MSB:EMI_CTL_WE_LSB];
    end
  end

  // Data bytes: software loads write data, a finished read reloads both
  emi_data_byte u_data_lo (
    .clock   (clock),
    .resetn  (resetn),
    .sw_we   (sw_wr && (sel == EMI_SEL_DL)),
    .sw_data (reg_wdata),
    .hw_we   (rd_done), // R13
    .hw_data (mem_rdata[7:0]),
    .q       (data_lo)
  );

  emi_data_byte u_data_hi (
    .clock   (clock),
    .resetn  (resetn),
    .sw_we   (sw_wr && (sel == EMI_SEL_DH)),
    .sw_data (reg_wdata),
    .hw_we   (rd_done), // R15
    .hw_data (mem_rdata[15:8]),
    .q       (data_hi)
  );

  // Memory port held steady for the whole access
  assign mem_req   = busy;
  assign mem_addr  = {addr_ff, 1'b0}; // R1
  assign mem_we    = busy ? we_ff : 2'h0; // R7
  assign mem_wdata = {data_hi, data_lo}; // R8 R9

  // Read path; reserved bits return zero
  always_comb begin
    nxt_rdata = 8'h00;
    case (sel)
      EMI_SEL_A86: begin
        nxt_rdata = {addr_ff[8:6], 5'h00}; // R3
      end
      EMI_SEL_A169: begin
        nxt_rdata = addr_ff[16:9];
      end
      EMI_SEL_A241: begin
        nxt_rdata = addr_ff[24:17];
      end
      EMI_SEL_A25: begin
        nxt_rdata = {7'h00, addr_ff[25]}; // R6
      end
      EMI_SEL_CTL: begin
        nxt_rdata = {busy, we_ff, addr_ff[5:1]}; // R11
      end
      EMI_SEL_DL: begin
        nxt_rdata = data_lo;
      end
      EMI_SEL_DH: begin
        nxt_rdata = data_hi;
      end
      default: begin
        nxt_rdata = 8'h00;
      end
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rdata_ff <= EMI_BYTE_RST;
    end else if (reg_rd) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;

  // Checks

  property p_ctl_addr;
    @(posedge clock) disable iff (!resetn)
    (sw_wr && reg_addr == EMI_OFS_CTL)
      |=> mem_addr[5:1] == $past(reg_wdata[4:0]) && mem_addr[0] == 1'b0;
  endproperty
  a_ctl_addr: assert property (p_ctl_addr) // R2
    else $error("address 5:1 not taken from control write");

  property p_le_a86_read;
    @(posedge clock) disable iff (!resetn)
    (reg_rd && !reg_wr && !big_end && reg_addr == EMI_OFS_30)
      |=> reg_rdata == {mem_addr[8:6], 5'h00};
  endproperty
  a_le_a86_read: assert property (p_le_a86_read) // R3
    else $error("little-endian 30h read wrong");

  property p_a169_place;
    @(posedge clock) disable iff (!resetn)
    (sw_wr && ((!big_end && reg_addr == EMI_OFS_31) ||
               (big_end && reg_addr == EMI_OFS_32)))
      |=> mem_addr[16:9] == $past(reg_wdata);
  endproperty
  a_a169_place: assert property (p_a169_place) // R4
    else $error("address 16:9 placed at wrong offset");

  property p_a2417_place;
    @(posedge clock) disable iff (!resetn)
    (sw_wr && ((!big_end && reg_addr == EMI_OFS_32) ||
               (big_end && reg_addr == EMI_OFS_31)))
      |=> mem_addr[24:17] == $past(reg_wdata);
  endproperty
  a_a2417_place: assert property (p_a2417_place) // R5
    else $error("address 24:17 placed at wrong offset");

  property p_a25_read;
    @(posedge clock) disable iff (!resetn)
    (reg_rd && !reg_wr && ((!big_end && reg_addr == EMI_OFS_33) ||
                           (big_end && reg_addr == EMI_OFS_30)))
      |=> reg_rdata == {7'h00, mem_addr[25]};
  endproperty
  a_a25_read: assert property (p_a25_read) // R6
    else $error("address bit 25 read wrong");

  property p_launch_kind;
    @(posedge clock) disable iff (!resetn)
    launch |=> mem_req && mem_we == $past(reg_wdata[6:5]);
  endproperty
  a_launch_kind: assert property (p_launch_kind) // R7
    else $error("access kind does not match enables");

  property p_write_data;
    @(posedge clock) disable iff (!resetn)
    (sw_wr && reg_addr == (big_end ? EMI_OFS_36 : EMI_OFS_37))
      ##1 !reg_wr ##1 launch
      |=> mem_wdata[15:8] == $past(reg_wdata, 3);
  endproperty
  a_write_data: assert property (p_write_data) // R8
    else $error("high write byte not presented");

  property p_done_clears;
    @(posedge clock) disable iff (!resetn)
    (mem_req && mem_ack) ##1 (!mem_req && !launch) ##1
      (reg_rd && reg_addr == EMI_OFS_CTL)
      |=> !reg_rdata[7] && !mem_req;
  endproperty
  a_done_clears: assert property (p_done_clears) // R11
    else $error("start bit not cleared after access");

  property p_read_load;
    @(posedge clock) disable iff (!resetn)
    (mem_req && mem_ack && mem_we == 2'h0)
      |=> mem_wdata == $past(mem_rdata);
  endproperty
  a_read_load: assert property (p_read_load) // R13 R15
    else $error("read data not loaded");

  property p_be_data_swap;
    @(posedge clock) disable iff (!resetn)
    (reg_rd && !reg_wr && !mem_ack && big_end &&
     reg_addr == EMI_OFS_36)
      |=> reg_rdata == mem_wdata[15:8];
  endproperty
  a_be_data_swap: assert property (p_be_data_swap) // R17
    else $error("big-endian 36h is not data high");

  property p_le_data_low;
    @(posedge clock) disable iff (!resetn)
    (reg_rd && !reg_wr && !mem_ack && !big_end &&
     reg_addr == EMI_OFS_36)
      |=> reg_rdata == mem_wdata[7:0];
  endproperty
  a_le_data_low: assert property (p_le_data_low) // R16
    else $error("little-endian 36h is not data low");

  property p_access_ends;
    @(posedge clock) disable iff (!resetn)
    (mem_req && mem_ack) |=> !mem_req && mem_we == 2'h0;
  endproperty
  a_access_ends: assert property (p_access_ends) // R11
    else $error("access did not end on acknowledge");

  // Blocked window writes must not disturb a running access
  property p_port_steady;
    @(posedge clock) disable iff (!resetn)
    (mem_req && !mem_ack) |=> mem_req && $stable(mem_addr) &&
      $stable(mem_we) && $stable(mem_wdata);
  endproperty
  a_port_steady: assert property (p_port_steady) // R18
    else $error("memory port changed during access");

endmodule

// [sim/emi_mem_model.sv]
// Behavioural extended memory behind the access window.
// Assumes mem_req holds until mem_ack; answers dly+1 cycles after mem_req rises.
`timescale 1ns/1ps
module emi_mem_model (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic [3:0]  dly,
  input  wire logic        mem_req,
  input  wire logic [25:0] mem_addr,
  input  wire logic [1:0]  mem_we,
  input  wire logic [15:0] mem_wdata,
  output logic             mem_ack,
  output logic      [15:0] mem_rdata
);
  logic [15:0] store [logic [25:0]];
  logic [3:0]  wait_ff;
  logic [15:0] word;

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      mem_ack <= 1'b0;
      wait_ff <= 4'h0;
      mem_rdata <= 16'h5a5a;
    end else if (mem_req && !mem_ack && wait_ff == dly) begin
      word = {mem_addr[16:1]} ^ 16'h3c5a;
      if (store.exists(mem_addr))
        word = store[mem_addr];
      // Lane merge, so partial writes keep the other byte
      if (mem_we[1])
        word[15:8] = mem_wdata[15:8];
      if (mem_we[0])
        word[7:0] = mem_wdata[7:0];
      store[mem_addr] = word;
      mem_ack <= 1'b1;
      wait_ff <= 4'h0;
      mem_rdata <= word;
    end else begin
      mem_ack <= 1'b0;
      wait_ff <= (mem_req && !mem_ack) ? wait_ff + 4'h1 : 4'h0;
      // Toggles off the ack cycle so a stale word never looks valid
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule

// [sim/emi_tb.sv]
// Self-checking bench for the extended memory access window.
// Assumes the design package and the behavioural memory model.
`timescale 1ns/1ps
module tb
  import emi_pkg::*;
;
  logic        clock, resetn, big_end, reg_wr, reg_rd, mem_req, mem_ack;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, dl, dh;
  logic [25:0] mem_addr, a;
  logic [1:0]  mem_we, we;
  logic [15:0] mem_wdata, mem_rdata, w;
  logic [3:0]  dly;
  logic [2:0]  k;
  logic        be, rd_seen, req_seen;
  logic [7:0]  wv [6];
  logic [7:0]  ev [6];
  logic [7:0]  rq [$];
  logic [43:0] aq [$];
  logic [15:0] shadow [logic [25:0]];
  int          fails, comparisons;

  emi_window u_emi_window (.clock(clock), .resetn(resetn),
    .big_end(big_end), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_we(mem_we),
    .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  emi_mem_model u_emi_mem_model (.clock(clock), .resetn(resetn),
    .dly(dly), .mem_req(mem_req), .mem_addr(mem_addr), .mem_we(mem_we),
    .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  initial clock = 1'b0;
  always #5 clock = ~clock;

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t: saw %0h, expected %0h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
    @(negedge clock);
    reg_addr = ofs;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] ofs, input logic [7:0] exp);
    @(negedge clock);
    reg_addr = ofs;
    reg_rd = 1'b1;
    rq.push_back(exp);
    @(negedge clock);
    reg_rd = 1'b0;
  endtask

  // Request rises one edge after the start write, so look a cycle later
  task automatic wait_idle;
    int n;
    n = 0;
    @(negedge clock);
    while (mem_req !== 1'b0 && n < 200) begin
      @(negedge clock);
      n++;
    end
    if (n >= 200) begin
      fails++;
      tally_and_finish();
    end
  endtask

  // Slot order: a8_6, a16_9, a24_17, a25, data low, data high
  function automatic logic [7:0] ofs(input int s, input logic b);
    logic [7:0] le [6] = '{EMI_OFS_30, EMI_OFS_31, EMI_OFS_32,
                           EMI_OFS_33, EMI_OFS_36, EMI_OFS_37};
    logic [7:0] bo [6] = '{EMI_OFS_33, EMI_OFS_32, EMI_OFS_31,
                           EMI_OFS_30, EMI_OFS_37, EMI_OFS_36};
    return b ? bo[s] : le[s];
  endfunction

  always @(posedge clock) rd_seen <= reg_rd;

  always @(negedge clock) begin
    if (rd_seen === 1'b1) begin
      if (rq.size() == 0)
        check(64'h1, 64'h0);
      else
        check(reg_rdata, rq.pop_front());
    end
    if (mem_req === 1'b1 && !req_seen) begin
      if (aq.size() == 0)
        check(64'h1, 64'h0);
      else
        check({mem_addr, mem_we, mem_wdata}, aq.pop_front());
    end
    req_seen = (mem_req === 1'b1);
  end

  initial begin
    resetn = 1'b0;
    big_end = 1'b0;
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
    dly = 4'h0;
    void'($urandom(32'h6325));
    repeat (20) @(posedge clock);
    @(negedge clock);
    resetn = 1'b1;
    for (int o = 8'h30; o < 8'h38; o++)
      rd(8'(o), 8'h00);
    // Unmapped offset swallows writes
    wr(8'h35, 8'hff);
    rd(8'h35, 8'h00);
    for (int i = 0; i < 8; i++) begin
      k = 3'(i);
      if (!k[0])
        a = 26'($urandom()) & 26'h3fffffe;
      be = k[1];
      we = k[0] ? 2'h0 : (k[2:1] == 2'h0 ? 2'h3 : k[2:1]);
      dl = 8'($urandom());
      dh = 8'($urandom());
      dly = (k == 3'h3) ? 4'h8 : 4'($urandom_range(0, 3));
      big_end = be;
      wv = '{{a[8:6], 5'h1f}, a[16:9], a[24:17], {7'h7f, a[25]}, dl, dh};
      ev = '{{a[8:6], 5'h00}, a[16:9], a[24:17], {7'h00, a[25]}, dl, dh};
      for (int s = 0; s < 6; s++)
        wr(ofs(s, be), wv[s]);
      for (int s = 0; s < 6; s++)
        rd(ofs(s, be), ev[s]);
      // Fields only; no access may start without bit 7
      wr(EMI_OFS_CTL, {1'b0, we, a[5:1]});
      rd(EMI_OFS_CTL, {1'b0, we, a[5:1]});
      aq.push_back({a, we, dh, dl});
      // High byte again just before start, so its path is checked
      wr(ofs(5, be), dh);
      wr(EMI_OFS_CTL, {1'b1, we, a[5:1]});
      if (k == 3'h3) begin
        rd(EMI_OFS_CTL, {1'b1, we, a[5:1]});
        wr(ofs(1, be), ~a[16:9]);
      end
      wait_idle();
      w = {a[16:1]} ^ 16'h3c5a;
      if (shadow.exists(a))
        w = shadow[a];
      if (we[1])
        w[15:8] = dh;
      if (we[0])
        w[7:0] = dl;
      shadow[a] = w;
      rd(EMI_OFS_CTL, {1'b0, we, a[5:1]});
      rd(ofs(1, be), a[16:9]);
      rd(ofs(4, be), w[7:0] & {8{we == 2'h0}} | dl & {8{we != 2'h0}});
      rd(ofs(5, be), w[15:8] & {8{we == 2'h0}} | dh & {8{we != 2'h0}});
    end
    // Second reset in mid-run clears the window again
    @(negedge clock);
    resetn = 1'b0;
    repeat (2) @(negedge clock);
    resetn = 1'b1;
    rd(EMI_OFS_31, 8'h00);
    rd(EMI_OFS_CTL, 8'h00);
    repeat (2) @(negedge clock);
    tally_and_finish();
  end
endmodule
